//--- ndrv_pkg.sv
// Purpose: Shared constants, codes and helpers of the flash drive-setup link
// Assumes: Both ends run on one 20 MHz clock
// Notes: Times are in ns; cycle counts are derived from the clock period
package ndrv_pkg;
    localparam int CLK_PERIOD_NS = 50;
    // Longest times round down
    localparam int T_PWR_RST_NS = 5000000;
    localparam int PWR_RST_CYC = T_PWR_RST_NS / CLK_PERIOD_NS;
    localparam int T_RST_NS = 5000;
    localparam int RST_CYC = T_RST_NS / CLK_PERIOD_NS;
    localparam int T_READ_NS = 50000;
    localparam int READ_CYC = T_READ_NS / CLK_PERIOD_NS;
    localparam int T_PROG_NS = 150000;
    localparam int PROG_CYC = T_PROG_NS / CLK_PERIOD_NS;
    localparam int T_ERASE_NS = 200000;
    localparam int ERASE_CYC = T_ERASE_NS / CLK_PERIOD_NS;
    typedef logic [16:0] ndrv_cnt_t;

    localparam logic [7:0] CMD_RESET = 8'hff;
    localparam logic [7:0] CMD_STAT = 8'h70;
    localparam logic [7:0] CMD_STAT1 = 8'hf1;
    localparam logic [7:0] CMD_STAT2 = 8'hf2;
    localparam logic [7:0] CMD_SETFEAT = 8'hef;
    localparam logic [7:0] CMD_PROG = 8'h80;
    localparam logic [7:0] CMD_PROG2 = 8'h10;
    localparam logic [7:0] CMD_ERASE = 8'h60;
    localparam logic [7:0] CMD_ERASE2 = 8'hd0;
    localparam logic [7:0] CMD_READ = 8'h00;
    localparam logic [7:0] CMD_READ2 = 8'h30;
    // Feature address of output_drive_strength
    localparam logic [7:0] FEAT_DRIVE = 8'h10;
    localparam logic [1:0] FEAT_LAST = 2'h3;
    localparam logic [7:0] DRV_UNDER = 8'h02;
    localparam logic [7:0] DRV_NOMINAL = 8'h04;
    localparam logic [7:0] DRV_OVER = 8'h06;
    localparam logic [7:0] DRV_RESET = DRV_NOMINAL;
    localparam logic [7:0] READ_FILL = 8'hff;
    localparam int ST_WP_BIT = 7;
    localparam int ST_RDY_BIT = 6;
    localparam int ST_TRDY_BIT = 5;
    localparam int ST_FAIL_BIT = 0;

    // Host registers, byte addresses
    localparam logic [7:0] HR_CTRL = 8'h00;
    localparam logic [7:0] HR_ARG = 8'h04;
    localparam logic [7:0] HR_WP = 8'h08;
    localparam logic [7:0] HR_STAT = 8'h0c;
    localparam logic [7:0] HR_INTST = 8'h10;
    localparam logic [7:0] HR_INTMSK = 8'h14;
    localparam int INT_DONE_BIT = 0;
    localparam int INT_REF_BIT = 1;
    localparam logic HOST_WP_RST = 1'b0;
    localparam logic [1:0] INT_MASK_RST = 2'h0;

    typedef enum logic [2:0] {
        OP_RESET = 3'b000,
        OP_STAT = 3'b001,
        OP_SETDRV = 3'b010,
        OP_PROG = 3'b011,
        OP_ERASE = 3'b100,
        OP_READ = 3'b101
    } ndrv_op_e;

    localparam logic [1:0] SK_END = 2'h0;
    localparam logic [1:0] SK_CMD = 2'h1;
    localparam logic [1:0] SK_ADR = 2'h2;
    localparam logic [1:0] SK_DAT = 2'h3;

    function automatic logic isStatCmd(input logic [7:0] b);
        return (b == CMD_STAT) || (b == CMD_STAT1) || (b == CMD_STAT2);
    endfunction

    function automatic logic isDriveVal(input logic [7:0] b);
        return (b == DRV_UNDER) || (b == DRV_NOMINAL) || (b == DRV_OVER);
    endfunction

    // Step of a host sequence: {use arg, kind, byte}
    function automatic logic [10:0] seqStep(input ndrv_op_e op, input logic [2:0] idx);
        logic [10:0] s;
        s = {1'b0, SK_END, 8'h00};
        case ({op, idx})
            {OP_RESET, 3'h0}: s = {1'b0, SK_CMD, CMD_RESET};
            {OP_STAT, 3'h0}: s = {1'b0, SK_CMD, CMD_STAT};
            {OP_SETDRV, 3'h0}: s = {1'b0, SK_CMD, CMD_SETFEAT};
            {OP_SETDRV, 3'h1}: s = {1'b0, SK_ADR, FEAT_DRIVE};
            {OP_SETDRV, 3'h2}: s = {1'b1, SK_DAT, 8'h00};
            {OP_SETDRV, 3'h3}: s = {1'b0, SK_DAT, 8'h00};
            {OP_SETDRV, 3'h4}: s = {1'b0, SK_DAT, 8'h00};
            {OP_SETDRV, 3'h5}: s = {1'b0, SK_DAT, 8'h00};
            {OP_PROG, 3'h0}: s = {1'b0, SK_CMD, CMD_PROG};
            {OP_PROG, 3'h1}: s = {1'b1, SK_ADR, 8'h00};
            {OP_PROG, 3'h2}: s = {1'b1, SK_DAT, 8'h00};
            {OP_PROG, 3'h3}: s = {1'b0, SK_CMD, CMD_PROG2};
            {OP_ERASE, 3'h0}: s = {1'b0, SK_CMD, CMD_ERASE};
            {OP_ERASE, 3'h1}: s = {1'b1, SK_ADR, 8'h00};
            {OP_ERASE, 3'h2}: s = {1'b0, SK_CMD, CMD_ERASE2};
            {OP_READ, 3'h0}: s = {1'b0, SK_CMD, CMD_READ};
            {OP_READ, 3'h1}: s = {1'b1, SK_ADR, 8'h00};
            {OP_READ, 3'h2}: s = {1'b0, SK_CMD, CMD_READ2};
            default: s = {1'b0, SK_END, 8'h00};
        endcase
        return s;
    endfunction
endpackage

//--- ndrv_if.sv
// Purpose: Command/strobe link between flash controller and flash device
// Assumes: Both ends on ref_clk; strobes are one-cycle pulses
// Notes: Completion line is open drain with a pull-up modelled here
`timescale 1ns/1ps
interface ndrv_if;
    logic cle;
    logic ale;
    logic wrStb;
    logic rdStb;
    logic [7:0] dq;
    logic [7:0] dqOut;
    logic wpN;
    logic rbOut;
    logic rbOeN;
    logic rbLine;

    // Pulled high unless the device pulls low
    assign rbLine = rbOeN | rbOut;

    modport dev (
        input cle,
        input ale,
        input wrStb,
        input rdStb,
        input dq,
        input wpN,
        output dqOut,
        output rbOut,
        output rbOeN
    );

    modport host (
        output cle,
        output ale,
        output wrStb,
        output rdStb,
        output dq,
        output wpN,
        input dqOut,
        input rbLine
    );
endinterface

//--- ndrv_device.sv
// Purpose: Flash device end: drive-strength feature, busy line, reset rules
// Assumes: Host strobes are on ref_clk; srst is the power-up event
// Notes: No cell array; reads return a fill byte
`timescale 1ns/1ps
module ndrv_device #(
    parameter int PwrRstCyc = ndrv_pkg::PWR_RST_CYC
) (
    input wire logic ref_clk,
    input wire logic srst,
    ndrv_if.dev link,
    output logic [7:0] driveStrength,
    output logic ready,
    output logic initDone,
    output logic opAborted
);
    typedef enum logic [2:0] {
        DEV_PWRUP = 3'b000,
        DEV_IDLE = 3'b001,
        DEV_ADDR = 3'b010,
        DEV_FADDR = 3'b011,
        DEV_FDATA = 3'b100
    } ndrv_dev_st_e;

    typedef struct packed {
        ndrv_dev_st_e st;
        logic [7:0] cmd;
        logic featHit;
        logic [1:0] pCnt;
        logic busy;
        ndrv_pkg::ndrv_cnt_t busyCnt;
        logic [7:0] drive;
        logic fail;
        logic statMode;
        logic [7:0] dqOut;
        logic aborted;
    } ndrv_dev_s;

    localparam ndrv_dev_s DEV_RST = '{
        st: DEV_PWRUP,
        drive: ndrv_pkg::DRV_RESET,
        default: '0
    };

    ndrv_dev_s q;
    ndrv_dev_s d;
    logic [7:0] statByte;
    logic cmdStb;
    logic adrStb;
    logic datStb;

    assign cmdStb = link.wrStb && link.cle;
    assign adrStb = link.wrStb && link.ale && !link.cle;
    assign datStb = link.wrStb && !link.ale && !link.cle;

    always_comb begin
        d = q;
        d.aborted = 1'b0;
        // Fail clears on reset, so a ready device with WP high reads C0h
        statByte = 8'h00;
        statByte[ndrv_pkg::ST_WP_BIT] = link.wpN;
        statByte[ndrv_pkg::ST_RDY_BIT] = ~q.busy;
        // Only cache operations report true ready; none exist here
        statByte[ndrv_pkg::ST_TRDY_BIT] = 1'b0;
        statByte[ndrv_pkg::ST_FAIL_BIT] = q.fail;

        // Busy ends when the count runs out
        if (q.busy) begin
            d.busyCnt = q.busyCnt - ndrv_pkg::ndrv_cnt_t'(1);
            if (q.busyCnt == ndrv_pkg::ndrv_cnt_t'(1)) begin
                d.busy = 1'b0;
            end
        end

        if (link.rdStb) begin
            if (q.statMode) begin
                d.dqOut = statByte;
            end else begin
                d.dqOut = ndrv_pkg::READ_FILL;
            end
        end

        if (cmdStb) begin
            if (link.dq == ndrv_pkg::CMD_RESET) begin
                // Accepted in any state, also while a reset is still busy
                d.aborted = q.busy && (q.st != DEV_PWRUP);
                d.busy = 1'b1;
                if (q.st == DEV_PWRUP) begin
                    d.busyCnt = ndrv_pkg::ndrv_cnt_t'(PwrRstCyc);
                end else begin
                    d.busyCnt = ndrv_pkg::ndrv_cnt_t'(ndrv_pkg::RST_CYC);
                end
                d.st = DEV_IDLE;
                d.fail = 1'b0;
                d.statMode = 1'b0;
                d.featHit = 1'b0;
            end else if (ndrv_pkg::isStatCmd(link.dq)) begin
                // Status reads stay legal while busy
                if (q.st != DEV_PWRUP) begin
                    d.statMode = 1'b1;
                end
            end else if (q.st != DEV_PWRUP && !q.busy) begin
                d.statMode = 1'b0;
                d.st = DEV_IDLE;
                case (link.dq)
                    ndrv_pkg::CMD_SETFEAT: begin
                        d.st = DEV_FADDR;
                    end
                    ndrv_pkg::CMD_PROG, ndrv_pkg::CMD_ERASE, ndrv_pkg::CMD_READ: begin
                        d.st = DEV_ADDR;
                        d.cmd = link.dq;
                    end
                    ndrv_pkg::CMD_PROG2: begin
                        // Cells change only after both program steps
                        if (q.st == DEV_ADDR && q.cmd == ndrv_pkg::CMD_PROG) begin
                            d.fail = ~link.wpN;
                            d.busy = link.wpN;
                            d.busyCnt = ndrv_pkg::ndrv_cnt_t'(ndrv_pkg::PROG_CYC);
                        end
                    end
                    ndrv_pkg::CMD_ERASE2: begin
                        if (q.st == DEV_ADDR && q.cmd == ndrv_pkg::CMD_ERASE) begin
                            d.fail = ~link.wpN;
                            d.busy = link.wpN;
                            d.busyCnt = ndrv_pkg::ndrv_cnt_t'(ndrv_pkg::ERASE_CYC);
                        end
                    end
                    ndrv_pkg::CMD_READ2: begin
                        if (q.st == DEV_ADDR && q.cmd == ndrv_pkg::CMD_READ) begin
                            d.fail = 1'b0;
                            d.busy = 1'b1;
                            d.busyCnt = ndrv_pkg::ndrv_cnt_t'(ndrv_pkg::READ_CYC);
                        end
                    end
                    default: begin
                        d.st = DEV_IDLE;
                    end
                endcase
            end
        end else if (adrStb) begin
            case (q.st)
                DEV_FADDR: begin
                    // Other features still take their four bytes, unused
                    d.featHit = (link.dq == ndrv_pkg::FEAT_DRIVE);
                    d.pCnt = 2'h0;
                    d.st = DEV_FDATA;
                end
                DEV_ADDR: begin
                    d.st = DEV_ADDR;
                end
                default: begin
                    d.st = q.st;
                end
            endcase
        end else if (datStb) begin
            if (q.st == DEV_FDATA) begin
                if (q.pCnt == 2'h0 && q.featHit && ndrv_pkg::isDriveVal(link.dq)) begin
                    d.drive = link.dq;
                end
                d.pCnt = q.pCnt + 2'h1;
                if (q.pCnt == ndrv_pkg::FEAT_LAST) begin
                    d.st = DEV_IDLE;
                end
            end
        end
    end

    // Synchronous reset stands for power-up
    always_ff @(posedge ref_clk) begin
        if (srst) begin
            q <= DEV_RST;
        end else begin
            q <= d;
        end
    end

    // Open drain: only ever pulls low, enable low while pulling
    assign link.rbOut = 1'b0;
    assign link.rbOeN = ~q.busy;
    assign link.dqOut = q.dqOut;
    assign driveStrength = q.drive;
    assign ready = ~q.busy;
    assign initDone = (q.st != DEV_PWRUP) && !q.busy;
    assign opAborted = q.aborted;
endmodule

//--- ndrv_host.sv
// Purpose: Flash controller end: APB register front, command sequencer
// Assumes: APB on ref_clk, zero wait states
// Notes: Reset command goes out on its own after srst
//
// Local design decision: the APB register port.
`timescale 1ns/1ps
module ndrv_host (
    input wire logic ref_clk,
    input wire logic srst,
    ndrv_if.host link,
    input wire logic [7:0] paddr,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [31:0] pwdata,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    output logic irq
);
    typedef enum logic [2:0] {
        H_IDLE = 3'b000,
        H_STEP = 3'b001,
        H_WAITRB = 3'b010,
        H_RDSTB = 3'b011,
        H_RDWAIT = 3'b100,
        H_RDCAP = 3'b101
    } ndrv_host_st_e;

    typedef struct packed {
        ndrv_host_st_e st;
        ndrv_pkg::ndrv_op_e op;
        logic [2:0] idx;
        logic [7:0] arg;
        logic wpEn;
        logic [7:0] lastStat;
        logic [1:0] intSt;
        logic [1:0] intMask;
        logic cle;
        logic ale;
        logic wrStb;
        logic rdStb;
        logic [7:0] dq;
        logic wpN;
        logic [31:0] prdata;
    } ndrv_host_s;

    localparam ndrv_host_s HOST_RST = '{
        st: H_STEP,
        op: ndrv_pkg::OP_RESET,
        wpEn: ndrv_pkg::HOST_WP_RST,
        wpN: ndrv_pkg::HOST_WP_RST,
        intMask: ndrv_pkg::INT_MASK_RST,
        default: '0
    };

    function automatic logic isMapped(input logic [7:0] a);
        return (a == ndrv_pkg::HR_CTRL) || (a == ndrv_pkg::HR_ARG) ||
            (a == ndrv_pkg::HR_WP) || (a == ndrv_pkg::HR_STAT) ||
            (a == ndrv_pkg::HR_INTST) || (a == ndrv_pkg::HR_INTMSK);
    endfunction

    ndrv_host_s q;
    ndrv_host_s d;
    logic [10:0] step;
    logic [1:0] intSet;
    logic [1:0] intClr;
    logic access;
    logic isStatOp;
    logic isAbortOp;
    ndrv_pkg::ndrv_op_e reqOp;

    assign access = psel && penable;
    assign reqOp = ndrv_pkg::ndrv_op_e'(pwdata[2:0]);
    assign isStatOp = (reqOp == ndrv_pkg::OP_STAT);
    // A reset may cut a running operation, but never the busy of a reset, power-up or later
    assign isAbortOp = (reqOp == ndrv_pkg::OP_RESET) && (q.op != ndrv_pkg::OP_RESET);

    always_comb begin
        d = q;
        d.cle = 1'b0;
        d.ale = 1'b0;
        d.wrStb = 1'b0;
        d.rdStb = 1'b0;
        intSet = 2'h0;
        intClr = 2'h0;
        step = ndrv_pkg::seqStep(q.op, q.idx);

        case (q.st)
            H_STEP: begin
                if (step[9:8] == ndrv_pkg::SK_END) begin
                    d.idx = 3'h0;
                    case (q.op)
                        ndrv_pkg::OP_STAT: d.st = H_RDSTB;
                        ndrv_pkg::OP_SETDRV: begin
                            d.st = H_IDLE;
                            intSet[ndrv_pkg::INT_DONE_BIT] = 1'b1;
                        end
                        default: d.st = H_WAITRB;
                    endcase
                end else begin
                    d.cle = (step[9:8] == ndrv_pkg::SK_CMD);
                    d.ale = (step[9:8] == ndrv_pkg::SK_ADR);
                    d.wrStb = 1'b1;
                    d.dq = step[10] ? q.arg : step[7:0];
                    d.idx = q.idx + 3'h1;
                end
            end
            H_WAITRB: begin
                // Any device holding the shared line low keeps us waiting
                if (link.rbLine) begin
                    d.st = H_IDLE;
                    intSet[ndrv_pkg::INT_DONE_BIT] = 1'b1;
                end
            end
            H_RDSTB: begin
                d.rdStb = 1'b1;
                d.st = H_RDWAIT;
            end
            H_RDWAIT: d.st = H_RDCAP;
            H_RDCAP: begin
                d.lastStat = link.dqOut;
                d.st = H_IDLE;
                intSet[ndrv_pkg::INT_DONE_BIT] = 1'b1;
            end
            default: d.st = H_IDLE;
        endcase

        // Write protect may only change while the line reads ready
        if (link.rbLine) begin
            d.wpN = q.wpEn;
        end

        if (psel && !penable && !pwrite) begin
            case (paddr)
                ndrv_pkg::HR_CTRL: d.prdata = {29'h0, q.op};
                ndrv_pkg::HR_ARG: d.prdata = {24'h0, q.arg};
                ndrv_pkg::HR_WP: d.prdata = {31'h0, q.wpEn};
                ndrv_pkg::HR_STAT: d.prdata = {16'h0, q.lastStat, 5'h0, q.wpN,
                    link.rbLine, q.st != H_IDLE};
                ndrv_pkg::HR_INTST: d.prdata = {30'h0, q.intSt};
                ndrv_pkg::HR_INTMSK: d.prdata = {30'h0, q.intMask};
                default: d.prdata = 32'h0;
            endcase
        end

        if (access && pwrite) begin
            case (paddr)
                ndrv_pkg::HR_CTRL: begin
                    // Status polls and a later reset may cut into a busy wait
                    if (pwdata[2:0] <= 3'h5 &&
                        ((q.st == H_IDLE && (link.rbLine || isStatOp)) ||
                        (q.st == H_WAITRB && (isStatOp || isAbortOp)))) begin
                        d.op = reqOp;
                        d.idx = 3'h0;
                        d.st = H_STEP;
                    end else begin
                        intSet[ndrv_pkg::INT_REF_BIT] = 1'b1;
                    end
                end
                ndrv_pkg::HR_ARG: d.arg = pwdata[7:0];
                ndrv_pkg::HR_WP: d.wpEn = pwdata[0];
                ndrv_pkg::HR_INTMSK: d.intMask = pwdata[1:0];
                default: d.arg = q.arg;
            endcase
        end
        if (access && !pwrite && paddr == ndrv_pkg::HR_INTST) begin
            // Clear only what the setup cycle captured, so a later event is not lost
            intClr = q.prdata[1:0];
        end
        // A new event wins over the read that clears it
        d.intSt = (q.intSt & ~intClr) | intSet;
    end

    // Reset starts the mandatory reset command, WP held low
    always_ff @(posedge ref_clk) begin
        if (srst) begin
            q <= HOST_RST;
        end else begin
            q <= d;
        end
    end

    assign link.cle = q.cle;
    assign link.ale = q.ale;
    assign link.wrStb = q.wrStb;
    assign link.rdStb = q.rdStb;
    assign link.dq = q.dq;
    assign link.wpN = q.wpN;
    assign prdata = q.prdata;
    assign pready = 1'b1;
    assign pslverr = access && !isMapped(paddr);
    assign irq = |(q.intSt & q.intMask);
endmodule

//--- ndrv_link_sva.sv
// Purpose: Protocol checks on the link between flash controller and device
// Assumes: One clock; srst synchronous active high
// Notes: The busy counter bounds the power-up reset and every busy period
`timescale 1ns/1ps
module ndrv_link_sva #(
    parameter int PwrRstCyc = 20
) (
    input wire logic ref_clk,
    input wire logic srst,
    input wire logic cle,
    input wire logic ale,
    input wire logic wrStb,
    input wire logic [7:0] dq,
    input wire logic wpN,
    input wire logic rbOut,
    input wire logic rbOeN,
    input wire logic rbLine
);
    default clocking cb @(posedge ref_clk);
    endclocking
    default disable iff (srst);
    logic cmdSeen_q;
    logic pwrDone_q;
    logic [31:0] busyCnt_q;
    always_ff @(posedge ref_clk) begin
        if (srst) begin
            cmdSeen_q <= 1'b0;
            pwrDone_q <= 1'b0;
            busyCnt_q <= 32'h0;
        end else begin
            cmdSeen_q <= cmdSeen_q | (wrStb & cle);
            busyCnt_q <= rbOeN ? 32'h0 : busyCnt_q + 32'h1;
            pwrDone_q <= pwrDone_q | (rbOeN & (busyCnt_q != 32'h0));
        end
    end
    sequence cmdOf(logic [7:0] b);
        wrStb && cle && dq == b;
    endsequence
    sequence adrByte;
        wrStb && ale;
    endsequence
    sequence progSeq;
        cmdOf(8'h80) ##1 adrByte ##1 (wrStb && !cle && !ale) ##1 cmdOf(8'h10);
    endsequence
    sequence eraseSeq;
        cmdOf(8'h60) ##1 adrByte ##1 cmdOf(8'hd0);
    endsequence
    sequence readSeq;
        cmdOf(8'h00) ##1 adrByte ##1 cmdOf(8'h30);
    endsequence
    a_first_cmd_reset: assert property (wrStb && cle && !cmdSeen_q |-> dq == 8'hff)
        else $error("first command was not reset");
    a_reset_goes_busy: assert property (cmdOf(8'hff) |=> !rbOeN)
        else $error("no busy after reset command");
    a_read_goes_busy: assert property (readSeq |=> !rbOeN)
        else $error("no busy after read start");
    a_prog_busy_wp: assert property (progSeq |=> rbOeN == !wpN)
        else $error("program busy does not follow write protect");
    a_erase_busy_wp: assert property (eraseSeq |=> rbOeN == !wpN)
        else $error("erase busy does not follow write protect");
    a_first_step_idle: assert property (wrStb && cle && dq == 8'h80 && rbOeN |=> rbOeN [*3])
        else $error("busy before second program step");
    a_open_drain: assert property (rbOut == 1'b0 && rbLine == rbOeN)
        else $error("completion line not open drain");
    a_pwr_busy_max: assert property (!pwrDone_q |-> busyCnt_q <= PwrRstCyc)
        else $error("power-up busy too long");
    // Busy lasts thousands of cycles, too long for a delay range, so the counter bounds it
    a_busy_released: assert property (busyCnt_q <= ndrv_pkg::ERASE_CYC + PwrRstCyc)
        else $error("busy never released");
    a_wp_hold_busy: assert property (!rbLine |=> $stable(wpN))
        else $error("write protect moved while busy");
endmodule

//--- nand_drive_setup_busy_powerup_bench.sv
// Purpose: Drives the controller over APB with the device on the far end
// Assumes: Zero-wait APB slave; power-up busy shortened to 20 cycles
// Notes: Busy lengths are checked as lower bounds from the package counts, the aborted read as an upper bound
`timescale 1ns/1ps
module nand_drive_setup_busy_powerup_bench;
    logic ref_clk;
    logic srst;
    logic [7:0] paddr;
    logic psel;
    logic penable;
    logic pwrite;
    logic [31:0] pwdata;
    logic [31:0] prdata;
    logic pready;
    logic pslverr;
    logic irq;
    logic [7:0] driveStrength;
    logic ready;
    logic initDone;
    logic opAborted;
    logic abortSeen = 1'b0;
    logic [31:0] q;
    logic [31:0] st;
    logic e;
    int errors = 0;
    int tests_run = 0;
    int cyc = 0;
    int t0;
    logic [7:0] drvIn [4] = '{8'h02, 8'h06, 8'h03, 8'h04};
    logic [7:0] drvExp [4] = '{8'h02, 8'h06, 8'h06, 8'h04};
    ndrv_if link();
    ndrv_device #(.PwrRstCyc(20)) ndrv_device_i (.ref_clk, .srst, .link(link.dev),
        .driveStrength, .ready, .initDone, .opAborted);
    ndrv_host ndrv_host_i (.ref_clk, .srst, .link(link.host), .paddr, .psel, .penable,
        .pwrite, .pwdata, .prdata, .pready, .pslverr, .irq);
    ndrv_link_sva #(.PwrRstCyc(20)) ndrv_link_sva_i (.ref_clk, .srst, .cle(link.cle),
        .ale(link.ale), .wrStb(link.wrStb), .dq(link.dq), .wpN(link.wpN),
        .rbOut(link.rbOut), .rbOeN(link.rbOeN), .rbLine(link.rbLine));
    initial begin
        ref_clk = 1'b0;
        forever #25 ref_clk = ~ref_clk;
    end
    always @(posedge ref_clk) cyc <= cyc + 1;
    // The abort flag is a one-cycle pulse; keep it for the later check
    always @(posedge ref_clk) begin
        if (opAborted === 1'b1) begin
            abortSeen <= 1'b1;
        end
    end
    task automatic report_and_stop();
        $display("mismatches %0d, comparisons %0d", errors, tests_run);
        if (errors == 0 && tests_run > 0) begin
            $display("[ PASS ]");
        end else begin
            $display("[ FAIL ]");
        end
        $finish;
    endtask
    task automatic check(input string what, input logic [31:0] exp, input logic [31:0] got);
        tests_run++;
        if (got !== exp) begin
            errors++;
            $display("unexpected %s: expected %h, seen %h", what, exp, got);
        end
    endtask
    // Entered just after a rising edge; leaves one idle edge so strobes never double-assign
    task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] d);
        int n;
        n = 0;
        psel <= 1'b1;
        pwrite <= wr;
        paddr <= a;
        pwdata <= d;
        @(posedge ref_clk);
        penable <= 1'b1;
        do begin
            @(posedge ref_clk);
            n++;
        end while (pready !== 1'b1 && n < 64);
        q = prdata;
        e = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
        @(posedge ref_clk);
        if (n >= 64) begin
            errors++;
            report_and_stop();
        end
    endtask
    task automatic poll(input logic [7:0] a, input int b);
        int n;
        n = 0;
        st = 32'h0;
        do begin
            apb(1'b0, a, 32'h0);
            st = st | q;
            n++;
        end while (q[b] !== 1'b1 && n < 3000);
        if (n >= 3000) begin
            errors++;
            report_and_stop();
        end
    endtask
    task automatic run(input logic [2:0] op);
        apb(1'b1, ndrv_pkg::HR_CTRL, {29'h0, op});
        poll(ndrv_pkg::HR_INTST, ndrv_pkg::INT_DONE_BIT);
    endtask
    initial begin
        srst = 1'b1;
        psel = 1'b0;
        penable = 1'b0;
        pwrite = 1'b0;
        paddr = 8'h00;
        pwdata = 32'h0;
        repeat (8) @(posedge ref_clk);
        srst <= 1'b0;
        @(posedge ref_clk);
        check("drive at power-up", 32'h04, {24'h0, driveStrength});
        // The reset command is taken one edge later; status is latched at setup
        @(posedge ref_clk);
        apb(1'b0, ndrv_pkg::HR_STAT, 32'h0);
        check("line in power-up reset", 32'h0, {31'h0, q[1]});
        apb(1'b0, ndrv_pkg::HR_INTMSK, 32'h0);
        check("mask reset", 32'h0, q);
        apb(1'b1, ndrv_pkg::HR_CTRL, 32'h3);
        poll(ndrv_pkg::HR_INTST, ndrv_pkg::INT_DONE_BIT);
        check("power-up events", 32'h3, {30'h0, st[1:0]});
        check("ready after reset", 32'h3, {30'h0, initDone, ready});
        $display("test power-up done");
        for (int i = 0; i < 4; i++) begin
            apb(1'b1, ndrv_pkg::HR_ARG, {24'h0, drvIn[i]});
            run(3'h2);
            check("drive strength", {24'h0, drvExp[i]}, {24'h0, driveStrength});
        end
        $display("test drive done");
        apb(1'b1, ndrv_pkg::HR_WP, 32'h1);
        run(3'h0);
        run(3'h1);
        apb(1'b0, ndrv_pkg::HR_STAT, 32'h0);
        check("status after reset", 32'hc0, {24'h0, q[15:8]});
        apb(1'b1, ndrv_pkg::HR_WP, 32'h0);
        run(3'h3);
        run(3'h1);
        apb(1'b0, ndrv_pkg::HR_STAT, 32'h0);
        check("protected program", 32'h41, {24'h0, q[15:8]});
        $display("test reset and protect done");
        apb(1'b1, ndrv_pkg::HR_WP, 32'h1);
        t0 = cyc;
        apb(1'b1, ndrv_pkg::HR_CTRL, 32'h3);
        // Command walk takes five cycles before the line falls
        repeat (6) @(posedge ref_clk);
        apb(1'b0, ndrv_pkg::HR_STAT, 32'h0);
        check("line in program", 32'h0, {31'h0, q[1]});
        apb(1'b1, ndrv_pkg::HR_CTRL, 32'h3);
        apb(1'b1, ndrv_pkg::HR_CTRL, 32'h1);
        poll(ndrv_pkg::HR_INTST, ndrv_pkg::INT_DONE_BIT);
        check("refused while busy", 32'h1, {31'h0, st[1]});
        apb(1'b0, ndrv_pkg::HR_STAT, 32'h0);
        check("status ready bit", 32'h0, {31'h0, q[14]});
        poll(ndrv_pkg::HR_STAT, 1);
        check("program length", 32'h1, {31'h0, (cyc - t0) >= ndrv_pkg::PROG_CYC});
        apb(1'b0, ndrv_pkg::HR_INTST, 32'h0);
        for (int i = 4; i < 6; i++) begin
            t0 = cyc;
            run(i[2:0]);
            check("busy length", 32'h1, {31'h0, (cyc - t0) >=
                (i == 4 ? ndrv_pkg::ERASE_CYC : ndrv_pkg::READ_CYC)});
        end
        t0 = cyc;
        apb(1'b1, ndrv_pkg::HR_CTRL, 32'h5);
        repeat (6) @(posedge ref_clk);
        apb(1'b1, ndrv_pkg::HR_CTRL, 32'h0);
        poll(ndrv_pkg::HR_INTST, ndrv_pkg::INT_DONE_BIT);
        check("read aborted", 32'h1, {31'h0, abortSeen});
        check("abort cut busy", 32'h1, {31'h0, (cyc - t0) < ndrv_pkg::READ_CYC});
        $display("test busy done");
        apb(1'b0, 8'h40, 32'h0);
        check("unmapped error", 32'h1, {31'h0, e});
        check("unmapped data", 32'h0, q);
        apb(1'b1, ndrv_pkg::HR_CTRL, 32'h1);
        // A status op is far shorter than this; no handshake is left to wait on
        repeat (20) @(posedge ref_clk);
        check("irq masked", 32'h0, {31'h0, irq});
        apb(1'b1, ndrv_pkg::HR_INTMSK, 32'h1);
        check("irq unmasked", 32'h1, {31'h0, irq});
        apb(1'b0, ndrv_pkg::HR_INTST, 32'h0);
        check("irq cleared", 32'h0, {31'h0, irq});
        $display("test interrupt done");
        report_and_stop();
    end
endmodule
